//--- include/spac_pkg.sv
// shared constants, encodings and carrier types for the setpoint alarm controller
package spac_pkg;
  // clock and time bases
  localparam int CLK_PERIOD_NS = 20;
  localparam int SEC_NS = 1_000_000_000;
  localparam int SEC_CYCLES_DEF = SEC_NS / CLK_PERIOD_NS;
  localparam int DEBOUNCE_NS = 20_000_000;
  localparam int DEB_CYCLES_DEF = DEBOUNCE_NS / CLK_PERIOD_NS;
  localparam int LONG_HOLD_SEC = 2;
  localparam int MENU_TIMEOUT_SEC = 60;
  localparam int SLOPE_DIV = 10000;

  // register byte offsets
  localparam logic [5:0] REG_CTRL = 6'h00;
  localparam logic [5:0] REG_DELAY = 6'h04;
  localparam logic [5:0] REG_RANGE = 6'h08;
  localparam logic [5:0] REG_STATUS = 6'h0c;
  localparam logic [5:0] REG_CORR = 6'h10;
  localparam logic [5:0] REG_CORR_PAR = 6'h14;
  localparam logic [5:0] REG_SWPT1 = 6'h18;
  localparam logic [5:0] REG_SWPT2 = 6'h1c;
  localparam logic [5:0] REG_ALARM = 6'h20;
  localparam logic [5:0] REG_ALDEL = 6'h24;

  // control field positions
  localparam int CTRL_FN_LSB = 0;
  localparam int CTRL_TEMP_BIT = 3;
  localparam int CTRL_CFG_LSB = 8;

  // reset values of software registers
  localparam logic [15:0] RST_DISP_LO = 16'hf831;
  localparam logic [15:0] RST_DISP_HI = 16'h270f;
  localparam logic [15:0] RST_DELAY = 16'h0001;
  localparam logic [7:0] RST_INPUT_CFG = 8'h00;

  // parameter limits and factory defaults
  localparam logic [15:0] ZERO_OFFSET_PARAM_MAX = 16'h0032;
  localparam logic [15:0] ZERO_OFFSET_PARAM_MIN = 16'hffce;
  localparam logic [15:0] SLOPE_MAX = 16'h00c8;
  localparam logic [15:0] SLOPE_MIN = 16'hff38;
  localparam logic [15:0] ALDEL_MAX = 16'h270f;
  localparam logic [15:0] DEF_ZERO = 16'h0000;

  // parameter slots of the menu
  localparam int NPARAM = 9;
  localparam logic [3:0] P_ZERO_OFFSET_PARAM = 4'h0;
  localparam logic [3:0] P_SLOPE = 4'h1;
  localparam logic [3:0] P_ON1 = 4'h2;
  localparam logic [3:0] P_OFF1 = 4'h3;
  localparam logic [3:0] P_ON2 = 4'h4;
  localparam logic [3:0] P_OFF2 = 4'h5;
  localparam logic [3:0] P_ALHI = 4'h6;
  localparam logic [3:0] P_ALLO = 4'h7;
  localparam logic [3:0] P_ALDEL = 4'h8;
  localparam logic [3:0] P_END = 4'hf;

  // output function selection
  typedef enum logic [2:0] {
    FN_NONE = 3'h0,
    FN_TWO_POINT = 3'h1,
    FN_THREE_POINT = 3'h2,
    FN_TWO_POINT_ALARM = 3'h3,
    FN_COMMON_MINMAX = 3'h4,
    FN_SEPARATE_MINMAX = 3'h5
  } spac_fn_e;

  // menu engine states
  typedef enum logic [2:0] {
    MS_IDLE = 3'b001,
    MS_CORR = 3'b010,
    MS_SETP = 3'b100
  } spac_menu_e;

  // debounced button events, bit 0 is button 1
  typedef struct packed {
    logic [2:0] press;
    logic [2:0] long_hold;
  } spac_btn_s;
endpackage : spac_pkg

//--- hdl/spac_btn.sv
// button synchroniser, debouncer and hold-time detector
`timescale 1ns/100ps
module spac_btn #(
  parameter int DEB_CYCLES = spac_pkg::DEB_CYCLES_DEF
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // seconds timebase
  input wire logic sec_tick,
  // raw buttons, high while pressed
  input wire logic [2:0] btn_raw,
  // events
  output spac_pkg::spac_btn_s ev
);
  logic [2:0] meta_r; // first stage, read only by sync_r
  logic [2:0] sync_r;
  logic [2:0] level_r; // debounced level
  logic [31:0] stab_r [3]; // cycles the synchronised level sync_r differs from level_r
  logic [1:0] hold_r [3]; // second ticks seen while held

  // two-flop synchroniser for the asynchronous pins
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_r <= 3'h0;
      sync_r <= 3'h0;
    end else begin
      meta_r <= btn_raw;
      sync_r <= meta_r;
    end
  end

  // debounce and hold measurement, one lane per button
  always_ff @(posedge clk) begin
    if (rst) begin
      level_r <= 3'h0;
      ev <= '0;
      for (int i = 0; i < 3; i++) begin
        stab_r[i] <= 32'h0;
        hold_r[i] <= 2'h0;
      end
    end else begin
      for (int i = 0; i < 3; i++) begin
        ev.press[i] <= 1'b0;
        ev.long_hold[i] <= 1'b0;
        // a level must stand for the whole window before it is believed
        if (sync_r[i] == level_r[i]) begin
          stab_r[i] <= 32'h0;
        end else if (stab_r[i] >= 32'(DEB_CYCLES - 1)) begin
          stab_r[i] <= 32'h0;
          level_r[i] <= sync_r[i];
          ev.press[i] <= sync_r[i];
        end else begin
          stab_r[i] <= stab_r[i] + 32'h1;
        end
        // ticks are not aligned to the press, so one extra tick proves the hold
        if (!level_r[i]) begin
          hold_r[i] <= 2'h0;
        end else if (sec_tick && hold_r[i] != 2'(spac_pkg::LONG_HOLD_SEC + 1)) begin
          hold_r[i] <= hold_r[i] + 2'h1;
          ev.long_hold[i] <= (hold_r[i] == 2'(spac_pkg::LONG_HOLD_SEC));
        end
      end
    end
  end
endmodule : spac_btn

//--- hdl/spac_core.sv
// setpoint and alarm controller: correction, switching, alarms, menu engine, register slave
`timescale 1ns/100ps
// Overview of operation
// - output stays off for the switching delay
// - menu idle over 60 s discards edits
// - input setting change restores factory defaults
// - button 3 held over 2 s opens correction
// - button 1 steps; last step commits values
// - buttons 2 and 3 step value within range
// - offset within plus minus 50, subtracted
// - temperature: (value - offset) times slope factor
// - standard signal: remove display low, re-add
// - button 1 held over 2 s opens setpoints
// - setpoint menu omits delay and drive type
// - function none refuses the setpoint menu
// - output 2 points only in three-point mode
// - on below off: low turns on
// - on above off: high turns on
// - alarm mode holds limits and 0-9999 delay
// - alarm after condition persists for delay
// - alarm output active when no alarm
// - commit stores values then requests reset
module spac_core #(
  parameter int SEC_CYCLES = spac_pkg::SEC_CYCLES_DEF,
  parameter int DEB_CYCLES = spac_pkg::DEB_CYCLES_DEF,
  parameter int VW = 16
) (
  // clock and reset
  input wire logic REF_CLK,
  input wire logic RST,
  // avalon-mm slave
  input wire logic [5:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  // front panel buttons, high while pressed
  input wire logic [2:0] BTN_RAW,
  // measured value from the converter
  input wire logic signed [VW-1:0] MEAS_VALUE,
  input wire logic MEAS_VALID,
  // switching outputs and results
  output logic OUT1,
  output logic OUT2,
  output logic signed [VW-1:0] CORR_VALUE,
  output logic NV_STORE,
  output logic DEV_RESET
);
  spac_pkg::spac_btn_s ev; // button events
  spac_pkg::spac_menu_e state_r; // menu state
  spac_pkg::spac_fn_e fn_r; // output function
  logic [31:0] sec_cnt_r; // seconds prescaler
  logic sec_tick_r; // one-cycle pulse each second
  logic wait_r; // waitrequest
  logic ctrl_temp_r; // temperature input when set
  logic [7:0] in_cfg_r; // input type, sensor and unit code
  logic signed [VW-1:0] disp_lo_r, disp_hi_r; // display range
  logic [15:0] dly_r [2]; // switching delays in seconds
  logic signed [VW-1:0] work_r [spac_pkg::NPARAM]; // values under edit
  logic signed [VW-1:0] comm_r [spac_pkg::NPARAM]; // committed values
  logic [3:0] idx_r; // parameter shown
  logic [6:0] idle_r; // seconds without a press
  logic nv_r; // store pulse
  logic rst_req_r; // reset request pulse
  logic signed [VW+1:0] x_r; // corrected value before slope
  logic x_vld_r;
  logic signed [VW-1:0] base_r; // display low term, zero for temperature
  logic signed [VW-1:0] corr_r;
  logic sw_r [2]; // controller outputs
  logic [16:0] hold_r [2]; // re-enable countdown in seconds
  logic [15:0] al_t_r [2]; // alarm persistence counters, high then low
  logic al_r [2]; // alarm active, high then low
  logic out1_r, out2_r;
  logic [31:0] rdata_r;

  // bus decode
  logic bus_req, wr_take, cfg_change;
  // menu events
  logic in_menu, open_corr, open_setp, advance, commit, timeout, any_press, dn, up;
  logic signed [VW-1:0] lim_lo, lim_hi, cur;
  logic en_sw [2];
  logic signed [2*VW+1:0] prod;

  // next parameter slot; the setpoint menu never visits delay or drive type
  function automatic logic [3:0] next_idx(input logic [3:0] i, input spac_pkg::spac_fn_e f);
    case (i)
      spac_pkg::P_ZERO_OFFSET_PARAM: next_idx = spac_pkg::P_SLOPE;
      spac_pkg::P_ON1: next_idx = spac_pkg::P_OFF1;
      spac_pkg::P_OFF1: begin
        if (f == spac_pkg::FN_THREE_POINT) next_idx = spac_pkg::P_ON2;
        else if (f == spac_pkg::FN_TWO_POINT_ALARM) next_idx = spac_pkg::P_ALHI;
        else next_idx = spac_pkg::P_END;
      end
      spac_pkg::P_ON2: next_idx = spac_pkg::P_OFF2;
      spac_pkg::P_ALHI: next_idx = spac_pkg::P_ALLO;
      spac_pkg::P_ALLO: next_idx = spac_pkg::P_ALDEL;
      default: next_idx = spac_pkg::P_END;
    endcase
  endfunction : next_idx

  // factory default of a slot; alarm limits span the reset display range
  function automatic logic signed [VW-1:0] def_val(input int i);
    if (i == int'(spac_pkg::P_ALHI)) def_val = VW'(signed'(spac_pkg::RST_DISP_HI));
    else if (i == int'(spac_pkg::P_ALLO)) def_val = VW'(signed'(spac_pkg::RST_DISP_LO));
    else def_val = VW'(spac_pkg::DEF_ZERO);
  endfunction : def_val

  // two-point hysteresis: direction set by which point is higher
  function automatic logic sw_next(input logic c, input logic signed [VW-1:0] v,
                                   input logic signed [VW-1:0] on, input logic signed [VW-1:0] off);
    if (on < off) sw_next = (v < on) ? 1'b1 : (v > off) ? 1'b0 : c;
    else sw_next = (v > on) ? 1'b1 : (v < off) ? 1'b0 : c;
  endfunction : sw_next

  // debounced buttons with hold detection
  spac_btn #(.DEB_CYCLES(DEB_CYCLES)) u_btn (
    .clk(REF_CLK),
    .rst(RST),
    .sec_tick(sec_tick_r),
    .btn_raw(BTN_RAW),
    .ev(ev)
  );

  // seconds timebase from the system clock
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      sec_cnt_r <= 32'h0;
      sec_tick_r <= 1'b0;
    end else begin
      sec_tick_r <= (sec_cnt_r == 32'(SEC_CYCLES - 1));
      sec_cnt_r <= (sec_cnt_r == 32'(SEC_CYCLES - 1)) ? 32'h0 : sec_cnt_r + 32'h1;
    end
  end

  // bus handshake: one wait cycle, the transfer completes on the edge after
  assign bus_req = AVS_READ | AVS_WRITE;
  assign wr_take = AVS_WRITE & ~wait_r;
  assign cfg_change = wr_take && AVS_ADDRESS[5:2] == spac_pkg::REG_CTRL[5:2]
                      && AVS_WRITEDATA[spac_pkg::CTRL_CFG_LSB+:8] != in_cfg_r;

  always_ff @(posedge REF_CLK) begin
    if (RST) wait_r <= 1'b1;
    else wait_r <= !(bus_req && wait_r);
  end

  // software registers; a changed input code is detected on the write itself
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      fn_r <= spac_pkg::FN_NONE;
      ctrl_temp_r <= 1'b1;
      in_cfg_r <= spac_pkg::RST_INPUT_CFG;
      disp_lo_r <= VW'(signed'(spac_pkg::RST_DISP_LO));
      disp_hi_r <= VW'(signed'(spac_pkg::RST_DISP_HI));
      dly_r[0] <= spac_pkg::RST_DELAY;
      dly_r[1] <= spac_pkg::RST_DELAY;
    end else if (wr_take) begin
      case (AVS_ADDRESS[5:2])
        spac_pkg::REG_CTRL[5:2]: begin
          // unknown function codes fall back to display only
          fn_r <= (AVS_WRITEDATA[2:0] > 3'(spac_pkg::FN_SEPARATE_MINMAX)) ? spac_pkg::FN_NONE
                  : spac_pkg::spac_fn_e'(AVS_WRITEDATA[spac_pkg::CTRL_FN_LSB+:3]);
          ctrl_temp_r <= AVS_WRITEDATA[spac_pkg::CTRL_TEMP_BIT];
          in_cfg_r <= AVS_WRITEDATA[spac_pkg::CTRL_CFG_LSB+:8];
        end
        spac_pkg::REG_DELAY[5:2]: begin
          dly_r[0] <= AVS_WRITEDATA[15:0];
          dly_r[1] <= AVS_WRITEDATA[31:16];
        end
        spac_pkg::REG_RANGE[5:2]: begin
          disp_lo_r <= AVS_WRITEDATA[VW-1:0];
          disp_hi_r <= AVS_WRITEDATA[16+:VW];
        end
        default: ; // other offsets are read only
      endcase
    end
  end

  // read data is captured as the request is first seen, ready for the completing edge
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      rdata_r <= 32'h0;
    end else if (AVS_READ && wait_r) begin
      case (AVS_ADDRESS[5:2])
        spac_pkg::REG_CTRL[5:2]: rdata_r <= {16'h0, in_cfg_r, 4'h0, ctrl_temp_r, fn_r};
        spac_pkg::REG_DELAY[5:2]: rdata_r <= {dly_r[1], dly_r[0]};
        spac_pkg::REG_RANGE[5:2]: rdata_r <= {16'(disp_hi_r), 16'(disp_lo_r)};
        spac_pkg::REG_STATUS[5:2]: rdata_r <= {20'h0, idx_r, 1'b0, state_r, al_r[1], al_r[0], out2_r, out1_r};
        spac_pkg::REG_CORR[5:2]: rdata_r <= 32'(corr_r);
        spac_pkg::REG_CORR_PAR[5:2]: rdata_r <= {16'(comm_r[spac_pkg::P_SLOPE]), 16'(comm_r[spac_pkg::P_ZERO_OFFSET_PARAM])};
        spac_pkg::REG_SWPT1[5:2]: rdata_r <= {16'(comm_r[spac_pkg::P_OFF1]), 16'(comm_r[spac_pkg::P_ON1])};
        spac_pkg::REG_SWPT2[5:2]: rdata_r <= {16'(comm_r[spac_pkg::P_OFF2]), 16'(comm_r[spac_pkg::P_ON2])};
        spac_pkg::REG_ALARM[5:2]: rdata_r <= {16'(comm_r[spac_pkg::P_ALLO]), 16'(comm_r[spac_pkg::P_ALHI])};
        spac_pkg::REG_ALDEL[5:2]: rdata_r <= {16'h0, 16'(comm_r[spac_pkg::P_ALDEL])};
        default: rdata_r <= 32'h0; // unmapped reads as zero
      endcase
    end
  end

  // menu events
  assign in_menu = (state_r != spac_pkg::MS_IDLE);
  assign any_press = |ev.press;
  assign open_corr = !in_menu && ev.long_hold[2];
  assign open_setp = !in_menu && ev.long_hold[0] && fn_r != spac_pkg::FN_NONE;
  assign advance = in_menu && ev.press[0];
  assign commit = advance && next_idx(idx_r, fn_r) == spac_pkg::P_END;
  assign timeout = in_menu && idle_r > 7'(spac_pkg::MENU_TIMEOUT_SEC);
  assign dn = in_menu && ev.press[1];
  assign up = in_menu && ev.press[2];
  assign cur = work_r[idx_r];

  // limits of the shown slot; alarm limits bound each other so they cannot cross
  always_comb begin
    lim_lo = disp_lo_r;
    lim_hi = disp_hi_r;
    case (idx_r)
      spac_pkg::P_ZERO_OFFSET_PARAM: begin
        lim_lo = VW'(signed'(spac_pkg::ZERO_OFFSET_PARAM_MIN));
        lim_hi = VW'(signed'(spac_pkg::ZERO_OFFSET_PARAM_MAX));
      end
      spac_pkg::P_SLOPE: begin
        lim_lo = VW'(signed'(spac_pkg::SLOPE_MIN));
        lim_hi = VW'(signed'(spac_pkg::SLOPE_MAX));
      end
      spac_pkg::P_ALHI: lim_lo = work_r[spac_pkg::P_ALLO];
      spac_pkg::P_ALLO: lim_hi = work_r[spac_pkg::P_ALHI];
      spac_pkg::P_ALDEL: begin
        lim_lo = VW'(spac_pkg::DEF_ZERO);
        lim_hi = VW'(signed'(spac_pkg::ALDEL_MAX));
      end
      default: ; // switch points use the display range
    endcase
  end

  // menu state, slot, inactivity timer and the store-then-reset sequence
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      state_r <= spac_pkg::MS_IDLE;
      idx_r <= spac_pkg::P_END;
      idle_r <= 7'h0;
      nv_r <= 1'b0;
      rst_req_r <= 1'b0;
    end else begin
      nv_r <= commit;
      rst_req_r <= nv_r; // reset follows the store by one cycle
      if (!in_menu || any_press) idle_r <= 7'h0;
      else if (sec_tick_r) idle_r <= idle_r + 7'h1;
      case (state_r)
        spac_pkg::MS_IDLE: begin
          if (open_corr) begin
            state_r <= spac_pkg::MS_CORR;
            idx_r <= spac_pkg::P_ZERO_OFFSET_PARAM;
          end else if (open_setp) begin
            state_r <= spac_pkg::MS_SETP;
            // min/max alarm functions start directly at the limits
            idx_r <= (fn_r == spac_pkg::FN_COMMON_MINMAX || fn_r == spac_pkg::FN_SEPARATE_MINMAX)
                     ? spac_pkg::P_ALHI : spac_pkg::P_ON1;
          end
        end
        spac_pkg::MS_CORR, spac_pkg::MS_SETP: begin
          if (commit || timeout || cfg_change) begin
            state_r <= spac_pkg::MS_IDLE;
            idx_r <= spac_pkg::P_END;
          end else if (advance) begin
            idx_r <= next_idx(idx_r, fn_r);
          end
        end
        default: begin
          state_r <= spac_pkg::MS_IDLE;
          idx_r <= spac_pkg::P_END;
        end
      endcase
    end
  end

  // working copy: reloaded on open, thrown away on timeout, stepped by buttons
  always_ff @(posedge REF_CLK) begin
    if (RST || cfg_change) begin
      for (int i = 0; i < spac_pkg::NPARAM; i++) work_r[i] <= def_val(i);
    end else if (open_corr || open_setp || timeout) begin
      for (int i = 0; i < spac_pkg::NPARAM; i++) work_r[i] <= comm_r[i];
    end else if (dn && cur > lim_lo) begin
      work_r[idx_r] <= cur - VW'(1);
    end else if (up && cur < lim_hi) begin
      work_r[idx_r] <= cur + VW'(1);
    end
  end

  // committed copy used by the controller
  always_ff @(posedge REF_CLK) begin
    if (RST || cfg_change) begin
      for (int i = 0; i < spac_pkg::NPARAM; i++) comm_r[i] <= def_val(i);
    end else if (commit) begin
      for (int i = 0; i < spac_pkg::NPARAM; i++) comm_r[i] <= work_r[i];
    end
  end

  // correction, stage one: remove offset and, for standard signals, the display low
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      x_r <= '0;
      base_r <= '0;
      x_vld_r <= 1'b0;
    end else begin
      x_vld_r <= MEAS_VALID;
      if (MEAS_VALID) begin
        base_r <= ctrl_temp_r ? VW'(0) : disp_lo_r;
        x_r <= (VW+2)'(MEAS_VALUE) - (VW+2)'(comm_r[spac_pkg::P_ZERO_OFFSET_PARAM])
               - (ctrl_temp_r ? (VW+2)'(0) : (VW+2)'(disp_lo_r));
      end
    end
  end

  // slope in hundredths of a percent of the offset-free value
  assign prod = (2*VW+2)'(x_r) * (2*VW+2)'(comm_r[spac_pkg::P_SLOPE]);

  // correction, stage two: apply slope and restore the display low term
  always_ff @(posedge REF_CLK) begin
    if (RST) corr_r <= '0;
    else if (x_vld_r) corr_r <= VW'(x_r + (VW+2)'(prod / (2*VW+2)'(spac_pkg::SLOPE_DIV))) + base_r;
  end

  assign en_sw[0] = (fn_r == spac_pkg::FN_TWO_POINT || fn_r == spac_pkg::FN_THREE_POINT
                     || fn_r == spac_pkg::FN_TWO_POINT_ALARM);
  assign en_sw[1] = (fn_r == spac_pkg::FN_THREE_POINT);

  // two controllers with a re-enable lockout after each switch-off
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      for (int k = 0; k < 2; k++) begin
        sw_r[k] <= 1'b0;
        hold_r[k] <= 17'h0;
      end
    end else begin
      for (int k = 0; k < 2; k++) begin
        if (!en_sw[k]) begin
          sw_r[k] <= 1'b0;
        end else if (sw_r[k] && !sw_next(1'b1, corr_r, comm_r[2+2*k], comm_r[3+2*k])) begin
          sw_r[k] <= 1'b0;
          // one extra tick because the first may come at once
          hold_r[k] <= 17'(dly_r[k]) + 17'h1;
        end else if (!sw_r[k] && hold_r[k] == 17'h0) begin
          sw_r[k] <= sw_next(1'b0, corr_r, comm_r[2+2*k], comm_r[3+2*k]);
        end
        if (sec_tick_r && hold_r[k] != 17'h0 && !(sw_r[k] && en_sw[k])) hold_r[k] <= hold_r[k] - 17'h1;
      end
    end
  end

  // alarm persistence: high limit on lane 0, low limit on lane 1
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      for (int k = 0; k < 2; k++) begin
        al_t_r[k] <= 16'h0;
        al_r[k] <= 1'b0;
      end
    end else begin
      for (int k = 0; k < 2; k++) begin
        if (k == 0 ? (corr_r <= comm_r[spac_pkg::P_ALHI]) : (corr_r >= comm_r[spac_pkg::P_ALLO])) begin
          al_t_r[k] <= 16'h0; // any return inside the band restarts the wait
          al_r[k] <= 1'b0;
        end else begin
          al_r[k] <= (al_t_r[k] >= 16'(comm_r[spac_pkg::P_ALDEL]));
          if (sec_tick_r && al_t_r[k] != 16'hffff) al_t_r[k] <= al_t_r[k] + 16'h1;
        end
      end
    end
  end

  // output routing per function; alarm outputs are driven while all is well
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      out1_r <= 1'b0;
      out2_r <= 1'b0;
    end else begin
      case (fn_r)
        spac_pkg::FN_TWO_POINT, spac_pkg::FN_THREE_POINT: begin
          out1_r <= sw_r[0];
          out2_r <= sw_r[1];
        end
        spac_pkg::FN_TWO_POINT_ALARM: begin
          out1_r <= sw_r[0];
          out2_r <= !(al_r[0] || al_r[1]);
        end
        spac_pkg::FN_COMMON_MINMAX: begin
          out1_r <= 1'b0;
          out2_r <= !(al_r[0] || al_r[1]);
        end
        spac_pkg::FN_SEPARATE_MINMAX: begin
          out1_r <= !al_r[0];
          out2_r <= !al_r[1];
        end
        default: begin
          out1_r <= 1'b0;
          out2_r <= 1'b0;
        end
      endcase
    end
  end

  // outputs straight from flip-flops
  assign AVS_READDATA = rdata_r;
  assign AVS_WAITREQUEST = wait_r;
  assign OUT1 = out1_r;
  assign OUT2 = out2_r;
  assign CORR_VALUE = corr_r;
  assign NV_STORE = nv_r;
  assign DEV_RESET = rst_req_r;
endmodule : spac_core

//--- tb/spac_chk.sv
// port checker for the setpoint alarm controller
`timescale 1ns/100ps
module spac_chk #(parameter int SEC_CYCLES = 50, parameter int VW = 16) (
  // clock and reset
  input wire logic REF_CLK,
  input wire logic RST,
  // register bus
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_READDATA,
  input wire logic AVS_WAITREQUEST,
  // measurement and results
  input wire logic MEAS_VALID,
  input wire logic OUT1,
  input wire logic signed [VW-1:0] CORR_VALUE,
  input wire logic NV_STORE,
  input wire logic DEV_RESET
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);
  // cycles since output 1 fell; starts saturated so power-up is not blocked
  int off_cnt_r;
  always_ff @(posedge REF_CLK) begin
    if (RST) off_cnt_r <= SEC_CYCLES;
    else if ($fell(OUT1)) off_cnt_r <= 1;
    else if (off_cnt_r < SEC_CYCLES) off_cnt_r <= off_cnt_r + 1;
  end
  // store pulse, then reset pulse, each one cycle
  sequence commit_s;
    NV_STORE ##1 (DEV_RESET && !NV_STORE) ##1 !DEV_RESET;
  endsequence
  wait_once_a: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST) else $error("wait low twice");
  wait_answer_a: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
    else $error("no answer");
  wait_idle_a: assert property (!(AVS_READ || AVS_WRITE) |=> AVS_WAITREQUEST) else $error("stray answer");
  rdata_hold_a: assert property ($changed(AVS_READDATA) |-> $past(AVS_READ) && $past(AVS_WAITREQUEST))
    else $error("read data moved");
  store_pair_a: assert property (NV_STORE |-> commit_s) else $error("bad commit pulses");
  reset_cause_a: assert property (DEV_RESET |-> $past(NV_STORE)) else $error("reset without store");
  corr_lat_a: assert property ($changed(CORR_VALUE) |-> $past(MEAS_VALID, 2)) else $error("late value");
  sw_delay_a: assert property ($rose(OUT1) |-> off_cnt_r >= SEC_CYCLES) else $error("on too soon");
endmodule : spac_chk
bind spac_core spac_chk #(.SEC_CYCLES(SEC_CYCLES), .VW(VW)) chk_u (.REF_CLK(REF_CLK), .RST(RST),
  .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
  .MEAS_VALID(MEAS_VALID), .OUT1(OUT1), .CORR_VALUE(CORR_VALUE), .NV_STORE(NV_STORE), .DEV_RESET(DEV_RESET));

//--- tb/spac_panel.sv
// front panel buttons pressed by an operator
`timescale 1ns/100ps
module spac_panel (
  // clock
  input wire logic clk,
  // raw buttons, high while pressed
  output logic [2:0] btn
);
  initial btn = 3'h0;
  // hold one button n cycles, then release long enough to pass debounce
  task automatic push(input int b, input int n);
    btn[b] <= 1'b1;
    repeat (n) @(posedge clk);
    btn[b] <= 1'b0;
    repeat (12) @(posedge clk);
  endtask : push
endmodule : spac_panel

//--- tb/test_setpoint_alarm_controller.sv
// self-checking bench for the setpoint alarm controller
`timescale 1ns/100ps
module test_setpoint_alarm_controller;
  localparam int SEC = 50; // short second keeps the 60 s timeout affordable
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [5:0] adr = 6'h00;
  logic rd_en = 1'b0;
  logic wr_en = 1'b0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat, got;
  logic wait_req, out1, out2, nv, dreset;
  logic [2:0] btn;
  logic signed [15:0] mval = 16'h0000;
  logic mvld = 1'b0;
  logic signed [15:0] corr;
  int errors = 0;
  int samples_checked = 0;
  always #10 clk = ~clk;
  spac_core #(.SEC_CYCLES(SEC), .DEB_CYCLES(4)) dut_u (.REF_CLK(clk), .RST(rst), .AVS_ADDRESS(adr),
    .AVS_READ(rd_en), .AVS_WRITE(wr_en), .AVS_WRITEDATA(wdat), .AVS_READDATA(rdat), .AVS_WAITREQUEST(wait_req),
    .BTN_RAW(btn), .MEAS_VALUE(mval), .MEAS_VALID(mvld), .OUT1(out1), .OUT2(out2), .CORR_VALUE(corr),
    .NV_STORE(nv), .DEV_RESET(dreset));
  spac_panel btn_u (.clk(clk), .btn(btn));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // one bus transfer, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
    rd_en <= !wr;
    wr_en <= wr;
    adr <= a;
    wdat <= d;
    do @(posedge clk); while (wait_req);
    got = rdat;
    rd_en <= 1'b0;
    wr_en <= 1'b0;
    @(posedge clk);
  endtask : bus
  task automatic rc(input logic [5:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(got, exp);
  endtask : rc
  // one measurement, then time for value and outputs to settle
  task automatic ms(input logic [15:0] v);
    mval <= v;
    mvld <= 1'b1;
    @(posedge clk);
    mvld <= 1'b0;
    repeat (5) @(posedge clk);
  endtask : ms
  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : summarize
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rc(6'h00, 32'h00000008);
    rc(6'h04, 32'h00010001);
    rc(6'h20, 32'hf831270f);
    bus(1'b1, 6'h14, 32'h00050005);
    rc(6'h14, 32'h0);
    rc(6'h3c, 32'h0);
    btn_u.push(0, 4 * SEC);
    rc(6'h0c, 32'h00000f10);
    $display("done registers");
    btn_u.push(2, 4 * SEC);
    rc(6'h0c, 32'h00000020);
    repeat (52) btn_u.push(2, 12);
    btn_u.push(0, 12);
    repeat (3) btn_u.push(1, 12);
    btn_u.push(0, 12);
    rc(6'h14, 32'hfffd0032);
    ms(16'h2742);
    rc(6'h10, 32'h0000270d);
    bus(1'b1, 6'h00, 32'h0);
    // chosen so that the truncated slope term differs from the temperature form
    ms(16'h1fd6);
    rc(6'h10, 32'h00001fa1);
    btn_u.push(2, 4 * SEC);
    btn_u.push(1, 12);
    repeat (63 * SEC) @(posedge clk);
    rc(6'h0c, 32'h00000f10);
    // reopen and commit at once: the abandoned offset step must not come back
    btn_u.push(2, 4 * SEC);
    repeat (2) btn_u.push(0, 12);
    rc(6'h14, 32'hfffd0032);
    bus(1'b1, 6'h00, 32'h00000109);
    rc(6'h14, 32'h0);
    $display("done correction");
    btn_u.push(0, 4 * SEC);
    // equal default points use the on-above-off form, so the held value turns output 1 on
    rc(6'h0c, 32'h00000241);
    repeat (3) btn_u.push(2, 12);
    btn_u.push(0, 12);
    repeat (5) btn_u.push(2, 12);
    btn_u.push(0, 12);
    rc(6'h18, 32'h00050003);
    // the commit switched output 1 off; let its lockout run out first
    repeat (2 * SEC) @(posedge clk);
    ms(16'h0002);
    rc(6'h0c, 32'h00000f11);
    ms(16'h0004);
    rc(6'h0c, 32'h00000f11);
    ms(16'h0006);
    rc(6'h0c, 32'h00000f10);
    ms(16'h0002);
    rc(6'h0c, 32'h00000f10);
    repeat (2 * SEC) @(posedge clk);
    ms(16'h0002);
    rc(6'h0c, 32'h00000f11);
    $display("done switching");
    bus(1'b1, 6'h00, 32'h0000010b);
    btn_u.push(0, 4 * SEC);
    repeat (4) btn_u.push(2, 12);
    repeat (4) btn_u.push(0, 12);
    repeat (2) btn_u.push(2, 12);
    btn_u.push(0, 12);
    rc(6'h24, 32'h00000002);
    repeat (2 * SEC) @(posedge clk);
    ms(16'h0008);
    rc(6'h0c, 32'h00000f13);
    ms(16'h0006);
    rc(6'h0c, 32'h00000f13);
    ms(16'h0004);
    rc(6'h0c, 32'h00000f12);
    ms(16'h2742);
    rc(6'h0c, 32'h00000f12);
    repeat (3 * SEC) @(posedge clk);
    ms(16'h2742);
    rc(6'h0c, 32'h00000f15);
    chk({out2, out1}, 32'h00000001);
    chk(corr, 32'h00002742);
    // remaining output functions, with the high alarm still active
    bus(1'b1, 6'h00, 32'h0000010a);
    ms(16'h2742);
    rc(6'h0c, 32'h00000f17);
    bus(1'b1, 6'h00, 32'h0000010d);
    rc(6'h0c, 32'h00000f16);
    bus(1'b1, 6'h00, 32'h0000010c);
    rc(6'h0c, 32'h00000f14);
    // an unknown function code falls back to display only
    bus(1'b1, 6'h00, 32'h0000010f);
    rc(6'h00, 32'h00000108);
    $display("done alarm");
    summarize();
  end
  // hang guard, well above the expected run length
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    summarize();
  end
endmodule : test_setpoint_alarm_controller
